// File: rtl/sdm_pkg.sv
// Shared constants and types of the deserialized-serial match-stop port.
`default_nettype none
package sdm_pkg;
   // Widths of the register port and of one deserialized frame.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int FRAME_W = 16;
   localparam int BITCNT_W = 5;
   localparam int DIV_W = 4;
   // Register byte offsets.
   localparam logic [7:0] OFF_MODULE_CFG = 8'h00;
   localparam logic [7:0] OFF_DESER_CFG0 = 8'h04;
   localparam logic [7:0] OFF_TX_DATA = 8'h08;
   localparam logic [7:0] OFF_MATCH_POL = 8'h0c;
   localparam logic [7:0] OFF_MATCH_MASK = 8'h10;
   localparam logic [7:0] OFF_RX_DATA = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_INT_MASK = 8'h1c;
   // Field positions.
   localparam int MC_MASTER_BIT = 0;
   localparam int MC_CONF_LSB = 4;
   localparam int DC_STOP_BIT = 0;
   localparam int ST_MATCH_BIT = 0;
   localparam int ST_FRAME_BIT = 1;
   localparam int ST_STOPPED_BIT = 2;
   localparam int ST_EVT_W = 2;
   // Port configuration code that selects deserialized-serial operation.
   localparam logic [1:0] CODE_DSI = 2'b01;
   // Reset values.
   localparam logic RST_MASTER = 1'b0;
   localparam logic [1:0] RST_CONF = 2'b00;
   localparam logic RST_STOP_EN = 1'b0;
   localparam logic [FRAME_W-1:0] RST_FRAME = 16'h0000;
   localparam logic [ST_EVT_W-1:0] RST_EVT = 2'b00;
   // Serial clock timing derived from the reference clock.
   localparam int CLK_PERIOD_NS = 8;
   localparam int SCK_PERIOD_NS = 64;
   localparam int SCK_HALF_CYC_RAW = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int SCK_HALF_CYC = (SCK_HALF_CYC_RAW < 1) ? 1 : SCK_HALF_CYC_RAW;
   localparam logic [DIV_W-1:0] SCK_HALF_LAST = DIV_W'(SCK_HALF_CYC - 1);
   localparam logic [BITCNT_W-1:0] LAST_BIT = BITCNT_W'(FRAME_W - 1);
   // Frame engine states, Gray coded along idle, lead, shift, trail.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_SHIFT = 2'b11,
      ST_TRAIL = 2'b10
   } sdm_state_t;
endpackage
`default_nettype wire

// File: rtl/sdm_shift_if.sv
// Interface between the match-stop controller and its frame engine.
`default_nettype none
interface sdm_shift_if;
   logic start;
   logic busy;
   logic done;
   logic [sdm_pkg::FRAME_W-1:0] tx;
   logic [sdm_pkg::FRAME_W-1:0] rx;
   logic miso;
   logic sck;
   logic cs_n;
   logic mosi;
   modport eng (input start, input tx, input miso,
                output busy, output done, output rx, output sck, output cs_n, output mosi);
   modport ctl (output start, output tx, output miso,
                input busy, input done, input rx, input sck, input cs_n, input mosi);
endinterface
`default_nettype wire

// File: rtl/sdm_shifter.sv
// Frame engine that shifts one deserialized frame out and in as master.
`default_nettype none
module sdm_shifter (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   sdm_shift_if.eng shf
);
   import sdm_pkg::*;

   sdm_state_t state_r;
   logic [DIV_W-1:0] div_r;
   logic [BITCNT_W-1:0] bit_r;
   logic [FRAME_W-1:0] tx_sh_r;
   logic [FRAME_W-1:0] rx_sh_r;
   logic sck_r;
   logic cs_n_r;
   logic mosi_r;
   logic done_r;
   wire tick = (div_r == SCK_HALF_LAST);

   // Handshake and pin outputs.
   assign shf.busy = (state_r != ST_IDLE);
   assign shf.done = done_r;
   assign shf.rx = rx_sh_r;
   assign shf.sck = sck_r;
   assign shf.cs_n = cs_n_r;
   assign shf.mosi = mosi_r;

   // Half-period divider of the serial clock, held at zero while idle.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_r <= '0;
      end else if (ce_i) begin
         div_r <= (state_r == ST_IDLE || tick) ? '0 : div_r + 4'h1;
      end
   end

   // Frame sequence: data changes on the falling edge, sampling on the rising edge.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r <= ST_IDLE;
         bit_r <= '0;
         tx_sh_r <= RST_FRAME;
         rx_sh_r <= RST_FRAME;
         sck_r <= 1'b0;
         cs_n_r <= 1'b1;
         mosi_r <= 1'b0;
         done_r <= 1'b0;
      end else if (ce_i) begin
         done_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (shf.start) begin
                  state_r <= ST_LEAD;
                  cs_n_r <= 1'b0;
                  tx_sh_r <= shf.tx;
                  mosi_r <= shf.tx[FRAME_W-1];
                  bit_r <= '0;
               end
            end
            ST_LEAD: begin
               if (tick) begin
                  state_r <= ST_SHIFT;
                  sck_r <= 1'b1;
                  rx_sh_r <= {rx_sh_r[FRAME_W-2:0], shf.miso};
               end
            end
            ST_SHIFT: begin
               if (tick && sck_r) begin
                  sck_r <= 1'b0;
                  if (bit_r == LAST_BIT) begin
                     state_r <= ST_TRAIL;
                  end else begin
                     mosi_r <= tx_sh_r[FRAME_W-2];
                     tx_sh_r <= {tx_sh_r[FRAME_W-2:0], 1'b0};
                     bit_r <= bit_r + 5'h01;
                  end
               end else if (tick) begin
                  sck_r <= 1'b1;
                  rx_sh_r <= {rx_sh_r[FRAME_W-2:0], shf.miso};
               end
            end
            ST_TRAIL: begin
               if (tick) begin
                  state_r <= ST_IDLE;
                  cs_n_r <= 1'b1;
                  done_r <= 1'b1;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   // Chip select stays low for the whole frame and the clock idles low outside it.
   AST_CS_LOW_IN_FRAME: assert property ((state_r == ST_SHIFT) |-> (!cs_n_r && !shf.cs_n))
      else $error("chip select high during shifting");
   AST_SCK_IDLE_LOW: assert property ((state_r == ST_IDLE) |-> !sck_r)
      else $error("serial clock high while idle");
endmodule
`default_nettype wire

// File: rtl/sdm_match_stop.sv
// Deserialized-serial master port with received-frame match and stop-on-match.
//
// Added by the designer: the plain strobed port and the register addresses.
`default_nettype none
module sdm_match_stop (
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   input wire logic [sdm_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [sdm_pkg::DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [sdm_pkg::DATA_W-1:0] RDATA_O,
   output logic IRQ_O,
   output logic SCK_O,
   output logic CS_N_O,
   output logic MOSI_O,
   input wire logic MISO_I
);
   import sdm_pkg::*;

   sdm_shift_if shf ();

   // Software-visible state.
   logic master_r;
   logic [1:0] conf_r;
   logic stop_en_r;
   logic [FRAME_W-1:0] tx_r;
   logic [FRAME_W-1:0] pol_r;
   logic [FRAME_W-1:0] mask_r;
   logic [FRAME_W-1:0] rx_r;
   logic [ST_EVT_W-1:0] sts_r;
   logic [ST_EVT_W-1:0] sts_nxt;
   logic [ST_EVT_W-1:0] imask_r;
   logic stopped_r;
   logic stopped_nxt;
   logic [DATA_W-1:0] rdata_r;
   // Receive line synchroniser.
   logic miso_s1_r;
   logic miso_s2_r;

   // Address decode of the write strobes.
   wire wr_mcfg = WR_I && (ADDR_I == OFF_MODULE_CFG);
   wire wr_dcfg = WR_I && (ADDR_I == OFF_DESER_CFG0);
   wire wr_tx = WR_I && (ADDR_I == OFF_TX_DATA);
   wire wr_pol = WR_I && (ADDR_I == OFF_MATCH_POL);
   wire wr_mask = WR_I && (ADDR_I == OFF_MATCH_MASK);
   wire wr_sts = WR_I && (ADDR_I == OFF_STATUS);
   wire wr_imask = WR_I && (ADDR_I == OFF_INT_MASK);

   // The port runs frames only as master in deserialized-serial mode.
   wire is_master = master_r;
   wire is_dsi = (conf_r == CODE_DSI);
   wire run_ok = is_master && is_dsi;

   // Frames follow each other back to back; the done cycle is left free for the check.
   assign shf.start = run_ok && !shf.busy && !shf.done && !stopped_r;
   assign shf.tx = tx_r;
   assign shf.miso = miso_s2_r;

   // Match of a finished frame: only enabled bits count, and at least one must be enabled.
   wire [FRAME_W-1:0] cmp_diff = (shf.rx ^ pol_r) & mask_r;
   wire match_w = (mask_r != RST_FRAME) && (cmp_diff == RST_FRAME);
   wire frame_evt = shf.done;
   wire match_evt = shf.done && match_w;

   // Sticky status: a new event wins over a write-one-to-clear in the same cycle.
   wire [ST_EVT_W-1:0] sts_set = {frame_evt, match_evt};
   wire [ST_EVT_W-1:0] sts_clr = wr_sts ? WDATA_I[ST_EVT_W-1:0] : RST_EVT;
   assign sts_nxt = (sts_r & ~sts_clr) | sts_set;

   // The stop latch is released only by leaving master deserialized mode.
   assign stopped_nxt = !run_ok ? 1'b0 :
                        (match_evt && stop_en_r) ? 1'b1 : stopped_r;

   // Interrupt is high while any unmasked status bit is set.
   assign IRQ_O = |(sts_r & imask_r);

   // Read selection, zero for unmapped offsets and above narrow fields.
   wire [DATA_W-1:0] rd_mcfg = DATA_W'({conf_r, 3'b000, master_r});
   wire [DATA_W-1:0] rd_sts = DATA_W'({stopped_r, sts_r});
   wire [DATA_W-1:0] rd_mux =
      (ADDR_I == OFF_MODULE_CFG) ? rd_mcfg :
      (ADDR_I == OFF_DESER_CFG0) ? DATA_W'(stop_en_r) :
      (ADDR_I == OFF_TX_DATA) ? DATA_W'(tx_r) :
      (ADDR_I == OFF_MATCH_POL) ? DATA_W'(pol_r) :
      (ADDR_I == OFF_MATCH_MASK) ? DATA_W'(mask_r) :
      (ADDR_I == OFF_RX_DATA) ? DATA_W'(rx_r) :
      (ADDR_I == OFF_STATUS) ? rd_sts :
      (ADDR_I == OFF_INT_MASK) ? DATA_W'(imask_r) : '0;

   // Pins come straight from the frame engine flip-flops.
   assign SCK_O = shf.sck;
   assign CS_N_O = shf.cs_n;
   assign MOSI_O = shf.mosi;
   assign RDATA_O = rdata_r;

   // Two-stage synchroniser of the receive pin.
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         miso_s1_r <= 1'b0;
         miso_s2_r <= 1'b0;
      end else if (CE_I) begin
         miso_s1_r <= MISO_I;
         miso_s2_r <= miso_s1_r;
      end
   end

   // Configuration registers written by software.
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         master_r <= RST_MASTER;
         conf_r <= RST_CONF;
         stop_en_r <= RST_STOP_EN;
      end else if (CE_I) begin
         if (wr_mcfg) begin
            master_r <= WDATA_I[MC_MASTER_BIT];
            conf_r <= WDATA_I[MC_CONF_LSB +: 2];
         end
         if (wr_dcfg) begin
            stop_en_r <= WDATA_I[DC_STOP_BIT];
         end
      end
   end

   // Frame data, match pattern and interrupt mask registers.
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         tx_r <= RST_FRAME;
         pol_r <= RST_FRAME;
         mask_r <= RST_FRAME;
         imask_r <= RST_EVT;
      end else if (CE_I) begin
         if (wr_tx) begin
            tx_r <= WDATA_I[FRAME_W-1:0];
         end
         if (wr_pol) begin
            pol_r <= WDATA_I[FRAME_W-1:0];
         end
         if (wr_mask) begin
            mask_r <= WDATA_I[FRAME_W-1:0];
         end
         if (wr_imask) begin
            imask_r <= WDATA_I[ST_EVT_W-1:0];
         end
      end
   end

   // Received frame capture, status flags and stop latch.
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rx_r <= RST_FRAME;
         sts_r <= RST_EVT;
         stopped_r <= 1'b0;
      end else if (CE_I) begin
         if (shf.done) begin
            rx_r <= shf.rx;
         end
         sts_r <= sts_nxt;
         stopped_r <= stopped_nxt;
      end
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rdata_r <= '0;
      end else if (CE_I) begin
         rdata_r <= RD_I ? rd_mux : '0;
      end
   end

   sdm_shifter u_shifter (
      .clk_i(REF_CLK_I),
      .nrst_i(NRST_I),
      .ce_i(CE_I),
      .shf(shf)
   );

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!NRST_I);

   // A finished frame whose enabled bits equal the programmed polarity.
   sequence seq_frame_match;
      CE_I && shf.done && match_w;
   endsequence

   // Eight cycles in a row with no frame launched.
   sequence seq_quiet8;
      (!shf.start)[*8];
   endsequence

   // A finished frame that is no match (an enabled bit differs or no bit is enabled), with the flag still clear.
   sequence seq_frame_miss;
      CE_I && shf.done && !match_w && !sts_r[ST_MATCH_BIT];
   endsequence

   AST_START_NEEDS_MASTER: assert property (shf.start |-> master_r)
      else $error("frame launched while not master");

   AST_START_NEEDS_DSI: assert property (shf.start |-> (conf_r == CODE_DSI))
      else $error("frame launched outside deserialized mode");

   AST_MATCH_SETS_FLAG: assert property (seq_frame_match |=> sts_r[ST_MATCH_BIT])
      else $error("matching frame did not set the match flag");

   AST_MISS_NO_FLAG: assert property (seq_frame_miss ##0 !wr_sts |=> !sts_r[ST_MATCH_BIT])
      else $error("match flag set by a differing frame");

   AST_MATCH_HALTS: assert property ((seq_frame_match ##0 stop_en_r) |-> ##1 seq_quiet8)
      else $error("frame launched after a stopping match");

   AST_NO_START_STOPPED: assert property (stopped_r |-> !shf.start)
      else $error("frame launched while stopped");

   AST_CLEAR_NO_RESUME: assert property (
      (stopped_r && run_ok && wr_sts && WDATA_I[ST_MATCH_BIT]) |=> stopped_r)
      else $error("clearing the match flag resumed transfers");

   AST_IRQ_ON_MATCH: assert property (
      ($rose(sts_r[ST_MATCH_BIT]) && imask_r[ST_MATCH_BIT]) |-> IRQ_O)
      else $error("unmasked match flag raised no interrupt");
endmodule
`default_nettype wire

// File: bench/sdm_slave_model.sv
// Behavioural serial slave that answers the deserialized frames of the port.
`default_nettype none
module sdm_slave_model (
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   input wire logic [sdm_pkg::FRAME_W-1:0] reply_i,
   output logic miso_o,
   output logic [sdm_pkg::FRAME_W-1:0] got_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import sdm_pkg::*;
   logic [FRAME_W-1:0] sh;
   // Start state, then the reply frame is loaded when the master selects us.
   initial begin
      miso_o = 1'b0;
      got_o = '0;
      sh = '0;
   end
   always @(negedge cs_n_i) begin
      sh = reply_i;
      miso_o = sh[FRAME_W-1];
   end
   // Capture the master's data on the rising serial clock, MSB first.
   always @(posedge sck_i) begin
      if (!cs_n_i) got_o <= {got_o[FRAME_W-2:0], mosi_i};
   end
   // Shift our reply on the falling serial clock.
   always @(negedge sck_i) begin
      if (!cs_n_i) begin
         sh = {sh[FRAME_W-2:0], 1'b0};
         miso_o = sh[FRAME_W-1];
      end
   end
   // A released line must not keep its last value, so it turns over.
   always @(posedge cs_n_i) miso_o = ~miso_o;
endmodule
`default_nettype wire

// File: bench/serial_port_deserial_match_stop_tb.sv
// Self-checking bench of the deserialized-serial match-stop port.
`default_nettype none
module serial_port_deserial_match_stop_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sdm_pkg::*;
   typedef struct packed {
      logic [15:0] pol;
      logic [15:0] mask;
      logic [15:0] reply;
      logic [15:0] tx;
      logic hit;
   } sdm_row_t;
   localparam int N_ROWS = 6;
   sdm_row_t rows [N_ROWS] = '{
      '{16'ha5a5, 16'hffff, 16'ha5a5, 16'h1234, 1'b1},
      '{16'ha5a5, 16'hffff, 16'ha5a4, 16'hfedc, 1'b0},
      '{16'h00f0, 16'h00f0, 16'h12f4, 16'h8001, 1'b1},
      '{16'h00f0, 16'h00f0, 16'h12e4, 16'h0000, 1'b0},
      '{16'h0000, 16'h0000, 16'h0000, 16'hffff, 1'b0},
      '{16'ha5a5, 16'hffff, 16'ha5a5, 16'h8001, 1'b1}};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic irq, sck, cs_n, mosi, miso;
   logic [FRAME_W-1:0] reply = '0;
   logic [FRAME_W-1:0] got;
   logic ce = 1'b1;
   logic [2:0] pins_hold;
   int n_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   sdm_match_stop dut (.REF_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .IRQ_O(irq),
      .SCK_O(sck), .CS_N_O(cs_n), .MOSI_O(mosi), .MISO_I(miso));
   sdm_slave_model slave (.sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .reply_i(reply),
      .miso_o(miso), .got_o(got));
   always #4 clk = ~clk;
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // A hung wait ends here as a mismatch.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         n_errors = n_errors + 1;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, sampled mid-cycle.
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask
   task automatic frame_end();
      @(posedge cs_n);
      @(negedge clk);
   endtask
   // Checks that no frame is started for n cycles.
   task automatic quiet(input int n);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(negedge clk);
         if (cs_n !== 1'b1) ok = 1'b0;
      end
      chk({31'h0, ok}, 32'h1);
   endtask
   // Main sequence: reset, table rows, then the awkward cases.
   initial begin
      repeat (11) @(posedge clk);
      @(negedge clk);
      chk({rdata[27:0], irq, sck, cs_n, mosi}, 32'h2);
      @(posedge clk);
      nrst <= 1'b1;
      rdchk(OFF_MODULE_CFG, 32'h0);
      rdchk(OFF_STATUS, 32'h0);
      rdchk(8'h20, 32'h0);
      wr(OFF_RX_DATA, 32'hffff);
      rdchk(OFF_RX_DATA, 32'h0);
      quiet(300);
      wr(OFF_MODULE_CFG, 32'h21);
      quiet(300);
      wr(OFF_MODULE_CFG, 32'h10);
      quiet(300);
      $display("reset and mode tests done");
      wr(OFF_INT_MASK, 32'h1);
      wr(OFF_MODULE_CFG, 32'h11);
      for (int i = 0; i < N_ROWS; i++) begin
         wr(OFF_MATCH_POL, {16'h0, rows[i].pol});
         wr(OFF_MATCH_MASK, {16'h0, rows[i].mask});
         wr(OFF_TX_DATA, {16'h0, rows[i].tx});
         frame_end();
         reply = rows[i].reply;
         wr(OFF_STATUS, 32'h3);
         frame_end();
         chk({16'h0, got}, {16'h0, rows[i].tx});
         repeat (2) @(negedge clk);
         chk({31'h0, irq}, {31'h0, rows[i].hit});
         rdchk(OFF_RX_DATA, {16'h0, rows[i].reply});
         rdchk(OFF_STATUS, {30'h0, 1'b1, rows[i].hit});
         rdchk(OFF_MATCH_MASK, {16'h0, rows[i].mask});
         $display("row %0d done", i);
      end
      wr(OFF_INT_MASK, 32'h0);
      repeat (2) @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      wr(OFF_INT_MASK, 32'h1);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      reply = 16'h0;
      frame_end();
      frame_end();
      wr(OFF_STATUS, 32'h1);
      repeat (2) @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      rdchk(OFF_STATUS, 32'h2);
      wr(OFF_INT_MASK, 32'h2);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      rdchk(OFF_INT_MASK, 32'h2);
      wr(OFF_INT_MASK, 32'h1);
      $display("interrupt test done");
      wr(OFF_DESER_CFG0, 32'h1);
      frame_end();
      reply = 16'ha5a5;
      frame_end();
      quiet(400);
      chk({31'h0, irq}, 32'h1);
      rdchk(OFF_STATUS, 32'h7);
      wr(OFF_STATUS, 32'h3);
      quiet(400);
      rdchk(OFF_STATUS, 32'h4);
      wr(OFF_DESER_CFG0, 32'h0);
      wr(OFF_MODULE_CFG, 32'h0);
      wr(OFF_MODULE_CFG, 32'h11);
      frame_end();
      frame_end();
      repeat (2) @(negedge clk);
      rdchk(OFF_STATUS, 32'h3);
      frame_end();
      chk({16'h0, got}, {16'h0, rows[N_ROWS-1].tx});
      $display("stop test done");
      // Freeze the port in mid-frame; the pins must hold and the frame must finish intact.
      repeat (10) @(negedge clk);
      @(posedge clk);
      ce <= 1'b0;
      @(negedge clk);
      pins_hold = {sck, cs_n, mosi};
      repeat (20) @(negedge clk);
      chk({29'h0, sck, cs_n, mosi}, {29'h0, pins_hold});
      chk({31'h0, cs_n}, 32'h0);
      @(posedge clk);
      ce <= 1'b1;
      frame_end();
      chk({16'h0, got}, {16'h0, rows[N_ROWS-1].tx});
      $display("clock enable test done");
      summarize();
   end
endmodule
`default_nettype wire
